// [design/setpoint_cfg.svh]
`ifndef SETPOINT_CFG_SVH
`define SETPOINT_CFG_SVH

`define CTRL_OFS 8'h00
`define STATUS_OFS 8'h04
`define CH0_BASE 4'h1
`define CH1_BASE 4'h2
`define CTRL_SP2_EN_BIT 0
`define CTRL_SERIAL_RST_BIT 1
`define CFG_STANDBY_BIT 4
`define CFG_BURNOUT_BIT 5
`define CFG_DISP_RST_BIT 6
`define CFG_COLOUR_BIT 7
`define CFG_ENABLE_BIT 8
`define CFG_RESET_VAL 9'h100
`define SP_MIN (-20'sd9999)
`define SP_MAX (20'sd99999)
`define SP_RESET_VAL 18'h00000
`define HYST_MIN 16'h0001
`define HYST_MAX 16'hea5f
`define HYST_RESET_VAL 16'h0001
`define DELAY_MAX 13'h176f
`define DELAY_OFF_LSB 16
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define CLK_PERIOD_NS 100
`define TICK_TIME_NS 100000000
`define TICK_CYCLES (`TICK_TIME_NS / `CLK_PERIOD_NS)

`endif

// [design/setpoint_pkg.sv]
package setpoint_pkg;

    typedef enum logic [1:0] {
        high_balanced_action,
        low_balanced_action,
        high_unbalanced_action,
        low_unbalanced_action
    } action_t;

    typedef enum logic [1:0] {
        auto_reset_mode,
        latch_immediate_mode,
        latch_delay_mode,
        spare_reset_mode
    } reset_mode_t;

endpackage : setpoint_pkg

// [design/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_t;

    sync_state_t st_q;
    sync_state_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.meta = pin_in;
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pin_sync_out = st_q.stable;
endmodule : pin_sync
`default_nettype wire

// [design/tenth_tick.sv]
`timescale 1ns/1ps
`default_nettype none
module tenth_tick #(
    parameter int TICK_CYCLES = 1000000
) (
    input wire logic aclk,
    input wire logic aresetn,
    output logic tick
);
    localparam int CW = $clog2(TICK_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } tick_state_t;

    tick_state_t st_q;
    tick_state_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (st_q.cnt == LAST) begin
            st_d.cnt = '0;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;
endmodule : tenth_tick
`default_nettype wire

// [design/setpoint_alarm_output.sv]
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "setpoint_cfg.svh"
module setpoint_alarm_output
    import setpoint_pkg::*;
#(
    parameter int NSP = 2,
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic signed [17:0] sample_value,
    input wire logic sample_valid,
    input wire logic probe_fail,
    input wire logic reset_button_pin,
    input wire logic user_input_pin,
    input wire logic display_reset,
    input wire logic reset_src_display,
    input wire logic input_shown,
    input wire logic [1:0] card_setpoints,
    output logic [NSP-1:0] sp_out,
    output logic backlight_alt
);
    typedef struct packed {
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic sp2_en;
        logic serial_rst;
        logic btn_prev;
        logic usr_prev;
        logic [NSP-1:0][8:0] cfg;
        logic [NSP-1:0][17:0] spv;
        logic [NSP-1:0][15:0] hyst;
        logic [NSP-1:0][12:0] on_dly;
        logic [NSP-1:0][12:0] off_dly;
        logic [NSP-1:0][12:0] cnt;
        logic [NSP-1:0] raw;
        logic [NSP-1:0] blk;
        logic [NSP-1:0] pend;
        logic [NSP-1:0] inh;
        logic [NSP-1:0] lat;
        logic [NSP-1:0] held;
        logic [NSP-1:0] drive;
        logic backlight;
    } state_t;

    state_t st_q;
    state_t st_d;
    logic [1:0] pins_s;
    logic tick;

    pin_sync #(.W(2)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in({user_input_pin, reset_button_pin}),
        .pin_sync_out(pins_s)
    );

    tenth_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register decoding helpers.

    // Returns 0 ctrl, 1 status, 4..7 channel 0, 8..11 channel 1, 15 unmapped.
    function automatic logic [3:0] reg_sel(input logic [7:0] a);
        logic [3:0] s;
        s = 4'hf;
        if (a[1:0] == 2'b00) begin
            if (a == `CTRL_OFS) begin
                s = 4'h0;
            end else if (a == `STATUS_OFS) begin
                s = 4'h1;
            end else if (a[7:4] == `CH0_BASE) begin
                s = {2'b01, a[3:2]};
            end else if (a[7:4] == `CH1_BASE && NSP > 1) begin
                s = {2'b10, a[3:2]};
            end
        end
        return s;
    endfunction : reg_sel

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic [12:0] clamp_dly(input logic [15:0] v);
        return (v > 16'(`DELAY_MAX)) ? `DELAY_MAX : v[12:0];
    endfunction : clamp_dly

    function automatic logic [31:0] reg_read(input state_t s, input logic [3:0] sel);
        logic [31:0] r;
        logic ch;
        r = '0;
        ch = sel[3];
        case (sel)
            4'h0: r[`CTRL_SP2_EN_BIT] = s.sp2_en;
            4'h1: r = {23'h0, s.backlight, 2'(s.inh), 2'(s.pend), 2'(s.raw), 2'(s.drive)};
            4'h4, 4'h8: r[8:0] = s.cfg[ch];
            4'h5, 4'h9: r = {{14{s.spv[ch][17]}}, s.spv[ch]};
            4'h6, 4'ha: r[15:0] = s.hyst[ch];
            4'h7, 4'hb: r = {3'h0, s.off_dly[ch], 3'h0, s.on_dly[ch]};
            default: r = '0;
        endcase
        return r;
    endfunction : reg_read

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: write address and data are taken together in one beat.

    assign awready = awvalid && wvalid && !st_q.bvalid;
    assign wready = awready;
    assign arready = !st_q.rvalid;

    ////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        logic [3:0] wsel;
        logic [31:0] wv;
        logic [31:0] old;
        logic wch;
        logic man_req;
        logic signed [19:0] v;
        logic signed [19:0] sp;
        logic signed [19:0] h;
        logic signed [19:0] hb;
        logic signed [19:0] on_pt;
        logic signed [19:0] off_pt;
        logic high;
        logic trig_on;
        logic trig_off;
        logic active;
        logic target;
        logic [12:0] dsel;
        action_t act;
        reset_mode_t mode;
        wsel = reg_sel(awaddr);
        wv = '0;
        old = '0;
        wch = wsel[3];
        man_req = 1'b0;
        v = '0;
        sp = '0;
        h = '0;
        hb = '0;
        on_pt = '0;
        off_pt = '0;
        high = 1'b0;
        trig_on = 1'b0;
        trig_off = 1'b0;
        active = 1'b0;
        target = 1'b0;
        dsel = '0;
        act = high_balanced_action;
        mode = auto_reset_mode;
        st_d = st_q;
        st_d.serial_rst = 1'b0;
        st_d.btn_prev = pins_s[0];
        st_d.usr_prev = pins_s[1];

        if (st_q.bvalid && bready) begin
            st_d.bvalid = 1'b0;
        end
        if (awready) begin
            st_d.bvalid = 1'b1;
            st_d.bresp = (wsel == 4'hf || wsel == 4'h1) ? `RESP_SLVERR : `RESP_OKAY;
            old = reg_read(st_q, wsel);
            wv = merge(old, wdata, wstrb);
            case (wsel)
                4'h0: begin
                    st_d.sp2_en = wv[`CTRL_SP2_EN_BIT];
                    st_d.serial_rst = wv[`CTRL_SERIAL_RST_BIT];
                end
                4'h4, 4'h8: st_d.cfg[wch] = wv[8:0];
                4'h5, 4'h9: begin
                    if ($signed(wv) < 32'(`SP_MIN)) begin
                        st_d.spv[wch] = 18'(`SP_MIN);
                    end else if ($signed(wv) > 32'(`SP_MAX)) begin
                        st_d.spv[wch] = 18'(`SP_MAX);
                    end else begin
                        st_d.spv[wch] = wv[17:0];
                    end
                end
                4'h6, 4'ha: begin
                    st_d.hyst[wch] = (wv[15:0] < `HYST_MIN) ? `HYST_MIN :
                                     (wv[15:0] > `HYST_MAX) ? `HYST_MAX : wv[15:0];
                end
                4'h7, 4'hb: begin
                    st_d.on_dly[wch] = clamp_dly(wv[15:0]);
                    st_d.off_dly[wch] = clamp_dly(wv[31:16]);
                end
                default: ;
            endcase
        end
        if (st_q.rvalid && rready) begin
            st_d.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = (reg_sel(araddr) == 4'hf) ? `RESP_SLVERR : `RESP_OKAY;
            st_d.rdata = reg_read(st_q, reg_sel(araddr));
        end

        st_d.backlight = 1'b0;
        for (int i = 0; i < NSP; i++) begin
            act = action_t'(st_q.cfg[i][1:0]);
            mode = reset_mode_t'(st_q.cfg[i][3:2]);
            active = st_q.cfg[i][`CFG_ENABLE_BIT] && (i < int'(card_setpoints))
                     && (i == 0 || st_q.sp2_en);
            man_req = (pins_s[0] && !st_q.btn_prev) || (pins_s[1] && !st_q.usr_prev)
                      || st_q.serial_rst || (display_reset && reset_src_display
                      && input_shown && st_q.cfg[i][`CFG_DISP_RST_BIT]);
            v = 20'(sample_value);
            sp = 20'($signed(st_q.spv[i]));
            h = 20'(st_q.hyst[i]);
            hb = h >>> 1;
            high = (act == high_balanced_action) || (act == high_unbalanced_action);
            case (act)
                high_balanced_action: begin
                    on_pt = sp + hb;
                    off_pt = sp - (h - hb);
                end
                low_balanced_action: begin
                    on_pt = sp - hb;
                    off_pt = sp + (h - hb);
                end
                high_unbalanced_action: begin
                    on_pt = sp;
                    off_pt = sp - h;
                end
                default: begin
                    on_pt = sp;
                    off_pt = sp + h;
                end
            endcase
            trig_on = high ? (v >= on_pt) : (v <= on_pt);
            trig_off = high ? (v <= off_pt) : (v >= off_pt);

            // Requests act first so that a sample in the same cycle still sets.
            if (man_req && active) begin
                case (mode)
                    auto_reset_mode: begin
                        st_d.held[i] = 1'b0;
                        st_d.blk[i] = 1'b1;
                    end
                    latch_immediate_mode: begin
                        st_d.lat[i] = 1'b0;
                        st_d.held[i] = 1'b0;
                        st_d.blk[i] = 1'b1;
                    end
                    latch_delay_mode: st_d.pend[i] = st_q.lat[i] || st_q.pend[i];
                    default: ;
                endcase
            end
            if (sample_valid) begin
                if (trig_on) begin
                    st_d.raw[i] = 1'b1;
                    st_d.inh[i] = 1'b0;
                    if (!st_q.blk[i] && mode != auto_reset_mode) begin
                        st_d.lat[i] = 1'b1;
                    end
                end else if (trig_off) begin
                    st_d.raw[i] = 1'b0;
                    st_d.blk[i] = 1'b0;
                    if (st_q.pend[i]) begin
                        st_d.lat[i] = 1'b0;
                        st_d.pend[i] = 1'b0;
                    end
                end
            end

            target = (mode == auto_reset_mode) ? (st_q.raw[i] && !st_q.blk[i]) : st_q.lat[i];
            if (!active || (st_q.cfg[i][`CFG_STANDBY_BIT] && st_q.inh[i])) begin
                target = 1'b0;
            end
            dsel = st_q.held[i] ? st_q.off_dly[i] : st_q.on_dly[i];
            if (man_req && active && mode != latch_delay_mode) begin
                st_d.cnt[i] = '0;
            end else if (target != st_q.held[i]) begin
                if (dsel == '0) begin
                    st_d.held[i] = target;
                    st_d.cnt[i] = '0;
                end else if (tick) begin
                    if (st_q.cnt[i] + 13'h0001 >= dsel) begin
                        st_d.held[i] = target;
                        st_d.cnt[i] = '0;
                    end else begin
                        st_d.cnt[i] = st_q.cnt[i] + 13'h0001;
                    end
                end
            end else begin
                st_d.cnt[i] = '0;
            end

            st_d.drive[i] = !active ? 1'b0 :
                            probe_fail ? st_q.cfg[i][`CFG_BURNOUT_BIT] : st_q.held[i];
            if (st_q.drive[i] && st_q.cfg[i][`CFG_COLOUR_BIT]) begin
                st_d.backlight = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
            st_q.inh <= '1;
            st_q.cfg <= {NSP{`CFG_RESET_VAL}};
            st_q.hyst <= {NSP{`HYST_RESET_VAL}};
            st_q.spv <= {NSP{`SP_RESET_VAL}};
        end else begin
            st_q <= st_d;
        end
    end

    assign bvalid = st_q.bvalid;
    assign bresp = st_q.bresp;
    assign rvalid = st_q.rvalid;
    assign rresp = st_q.rresp;
    assign rdata = st_q.rdata;
    assign sp_out = st_q.drive;
    assign backlight_alt = st_q.backlight;

    ////////////////////////////////////////////////////////////////////////
    // Checks on setpoint 0, and on both outputs without card support.

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic act0;
    reset_mode_t mode0;
    logic req0;
    assign act0 = st_q.cfg[0][`CFG_ENABLE_BIT] && (card_setpoints != 2'b00);
    assign mode0 = reset_mode_t'(st_q.cfg[0][3:2]);
    assign req0 = st_q.serial_rst && act0;

    sequence s_pend_armed;
        mode0 == latch_delay_mode && st_q.pend[0] && !awready;
    endsequence

    sequence s_off_sample;
        sample_valid && !st_q.blk[0];
    endsequence

    chk_burnout_force: assert property (
        act0 && probe_fail |=> sp_out[0] == $past(st_q.cfg[0][`CFG_BURNOUT_BIT]))
        else $error("burn-out state not forced");
    chk_card_limit: assert property (
        card_setpoints == 2'b00 |=> sp_out == '0)
        else $error("output active without card support");
    chk_imm_reset: assert property (
        req0 && mode0 == latch_immediate_mode && !awready |=> !st_q.held[0] && !st_q.lat[0])
        else $error("latched output not reset at once");
    chk_auto_reset: assert property (
        req0 && mode0 == auto_reset_mode && !awready |=> !st_q.held[0] && st_q.blk[0])
        else $error("auto output not reset by request");
    chk_delay_pend: assert property (
        req0 && mode0 == latch_delay_mode && st_q.lat[0] && !awready
        |=> st_q.pend[0] && st_q.lat[0])
        else $error("delayed reset not remembered");
    chk_pend_clear: assert property (
        s_pend_armed ##0 s_off_sample ##0 (st_d.raw[0] == 1'b0 && st_q.raw[0] == 1'b1)
        |=> !st_q.lat[0] && !st_q.pend[0])
        else $error("pending reset not applied at trigger-off");
    chk_standby_inh: assert property (
        st_q.cfg[0][`CFG_STANDBY_BIT] && st_q.inh[0] && !probe_fail && !awready
        |=> ##1 !sp_out[0] || !$past(st_q.inh[0]))
        else $error("standby output not inhibited");
    chk_zero_delay: assert property (
        act0 && !probe_fail && !st_q.blk[0] && st_q.on_dly[0] == '0 && !st_q.held[0]
        && st_q.raw[0] && mode0 == auto_reset_mode && !st_q.inh[0] && !req0 && !awready
        && pins_s == 2'b00 && !display_reset
        |=> st_q.held[0] ##1 (sp_out[0] || $past(probe_fail)))
        else $error("zero delay did not switch at once");
    chk_colour_follow: assert property (
        st_q.cfg[0][`CFG_COLOUR_BIT] && sp_out[0] |=> backlight_alt)
        else $error("backlight does not follow output");
endmodule : setpoint_alarm_output
`default_nettype wire

// [tb/output_card.sv]
`timescale 1ns/1ps
`default_nettype none
// Relay card model: contacts close one clock after the coil, like a slow mechanical part.
module output_card #(
    parameter int N = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [N-1:0] coil,
    output logic [N-1:0] contact
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            contact <= '0;
        end else begin
            contact <= coil;
        end
    end
endmodule : output_card
`default_nettype wire

// [tb/setpoint_alarm_output_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module setpoint_alarm_output_tb_top;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sample_valid, probe_fail;
    logic awready, wready, bvalid, arready, rvalid, backlight_alt, src_disp, shown;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, card_sp, sp_out, load_on, r;
    logic signed [17:0] sample_value;
    logic [2:0] req_q;
    int n_mismatch, comparisons;
    int tv[4][4] = '{'{104, 105, 96, 95}, '{96, 95, 104, 105},
                     '{99, 100, 91, 90}, '{101, 100, 109, 110}};

    setpoint_alarm_output #(.NSP(2), .TICK_CYCLES(10)) u_setpoint_alarm_output (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .sample_value(sample_value), .sample_valid(sample_valid), .probe_fail(probe_fail),
        .reset_button_pin(req_q[0]), .user_input_pin(req_q[1]), .display_reset(req_q[2]),
        .reset_src_display(src_disp), .input_shown(shown), .card_setpoints(card_sp),
        .sp_out(sp_out), .backlight_alt(backlight_alt));

    output_card #(.N(2)) u_output_card (
        .aclk(aclk), .aresetn(aresetn), .coil(sp_out), .contact(load_on));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk_reg

    task automatic chk_pin(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %b seen %b", n, e, g);
        end
    endtask : chk_pin

    // Address and data go out together; each is held until the edge that takes it.
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do @(negedge aclk); while (!(awready && wready));
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(negedge aclk); while (!bvalid);
        r = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask : settle

    task automatic smp(input int v);
        @(posedge aclk);
        sample_value <= 18'(v);
        sample_valid <= 1'b1;
        @(posedge aclk);
        sample_valid <= 1'b0;
        settle(4);
    endtask : smp

    // Pins pass a two-flop synchroniser, so a request is held for a few clocks.
    task automatic pulse(input int k, input int n);
        @(posedge aclk);
        req_q[k] <= 1'b1;
        repeat (n) @(posedge aclk);
        req_q[k] <= 1'b0;
        settle(8);
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        end_sim();
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, sample_valid, probe_fail} = '0;
        {src_disp, shown, awaddr, araddr, wdata, req_q} = '0;
        sample_value = '0;
        wstrb = 4'hf;
        card_sp = 2'h2;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h10); chk_reg("cfg0", 32'h100, d);
        rd(8'h30); chk_reg("unmapped", 32'h2, {30'h0, r});
        wr(8'h04, 32'h0); chk_reg("status write", 32'h2, {30'h0, r});
        wr(8'h14, -32'sd20000); rd(8'h14); chk_reg("sp low", 32'hffffd8f1, d);
        wr(8'h14, 32'd200000); rd(8'h14); chk_reg("sp high", 32'h1869f, d);
        wr(8'h18, 32'h0); rd(8'h18); chk_reg("hyst low", 32'h1, d);
        wr(8'h18, 32'd60000); rd(8'h18); chk_reg("hyst high", 32'hea5f, d);
        wr(8'h1c, 32'hffffffff); rd(8'h1c); chk_reg("delays", 32'h176f176f, d);
        wr(8'h1c, 32'h0);
        wr(8'h14, 32'd100);
        wr(8'h18, 32'd10);
        for (int a = 0; a < 4; a++) begin
            wr(8'h10, 32'h100 | a);
            for (int i = 0; i < 4; i++) begin
                smp(tv[a][i]);
                chk_pin("action", (i == 1 || i == 2), load_on[0]);
            end
        end
        wr(8'h10, 32'h100);
        wr(8'h1c, 32'h00020003);
        smp(105); settle(10); chk_pin("on delay", 1'b0, load_on[0]);
        settle(40); chk_pin("on delay", 1'b1, load_on[0]);
        smp(95); settle(2); chk_pin("off delay", 1'b1, load_on[0]);
        settle(30); chk_pin("off delay", 1'b0, load_on[0]);
        wr(8'h1c, 32'h0);
        smp(105); pulse(0, 3); chk_pin("auto reset", 1'b0, load_on[0]);
        smp(106); chk_pin("auto hold", 1'b0, load_on[0]);
        smp(95); smp(105); chk_pin("auto retrig", 1'b1, load_on[0]);
        wr(8'h10, 32'h140);
        pulse(2, 1); chk_pin("disp off src", 1'b1, load_on[0]);
        src_disp <= 1'b1;
        shown <= 1'b1;
        pulse(2, 1); chk_pin("disp reset", 1'b0, load_on[0]);
        wr(8'h10, 32'h104);
        smp(95); smp(105); smp(95); chk_pin("latched", 1'b1, load_on[0]);
        pulse(1, 3); chk_pin("user reset", 1'b0, load_on[0]);
        smp(105); chk_pin("no retrig", 1'b0, load_on[0]);
        smp(95); smp(105); chk_pin("retrig", 1'b1, load_on[0]);
        wr(8'h00, 32'h2); settle(4); chk_pin("serial reset", 1'b0, load_on[0]);
        wr(8'h10, 32'h108);
        smp(95); smp(105); pulse(0, 3); chk_pin("pending", 1'b1, load_on[0]);
        smp(100); chk_pin("pending", 1'b1, load_on[0]);
        smp(95); chk_pin("applied", 1'b0, load_on[0]);
        wr(8'h10, 32'h100);
        smp(105);
        probe_fail <= 1'b1;
        settle(4); chk_pin("burn off", 1'b0, load_on[0]);
        wr(8'h10, 32'h120); settle(4); chk_pin("burn on", 1'b1, load_on[0]);
        probe_fail <= 1'b0;
        wr(8'h10, 32'h180);
        smp(95); smp(105); chk_pin("backlight", 1'b1, backlight_alt);
        smp(95); chk_pin("backlight", 1'b0, backlight_alt);
        wr(8'h00, 32'h1); smp(105); chk_pin("sp2 on", 1'b1, sp_out[1]);
        wr(8'h00, 32'h0); settle(4); chk_pin("sp2 off", 1'b0, sp_out[1]);
        wr(8'h00, 32'h1);
        card_sp <= 2'h1;
        settle(4); chk_pin("card limit", 1'b0, sp_out[1]);
        end_sim();
    end
endmodule : setpoint_alarm_output_tb_top
`default_nettype wire
